// [include/sgc_pkg.sv]
package sgc_pkg;
  // register map
  localparam logic [7:0] GEN_CFG_OFFSET = 8'h03;
  localparam logic [7:0] GEN_CFG_RESET  = 8'hD2;
  localparam logic [7:0] GEN_CFG_RW_MASK = 8'hB8;
  // field positions
  localparam int CRC_CHECK_EN_BIT = 7;
  localparam int AUTO_ACK_BIT     = 5;
  localparam int SYNC_FILTER_BIT  = 4;
  localparam int PASS_THRU_BIT    = 3;
  // alias table and filter timing
  localparam int ALIAS_COUNT  = 8;
  localparam int ADDR_WIDTH   = 7;
  localparam int VIDEO_CHANS  = 3;
  localparam logic [1:0] FILTER_TICKS = 2'h2;
endpackage

// [sim/serializer_general_config_tb.sv]
`timescale 1ns/1ps
module serializer_general_config_tb;
  import sgc_pkg::*;
  logic i_clock = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0, i_remote_wr_byte = 0;
  logic i_target_is_deser = 0, i_pass_all = 0, i_pixel_tick = 0, i_addr_valid = 0;
  logic i_video_data_valid = 0, i_horizontal_sync_input = 0, i_vertical_sync_input = 0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_alias_used = 8'h81;
  logic [ADDR_WIDTH-1:0] i_addr = 7'h00;
  logic [ALIAS_COUNT*ADDR_WIDTH-1:0] i_remote_target_alias = {7'h2A, 21'h0, 7'h33, 14'h0, 7'h11};
  logic o_crc_check_en, o_master_ack, o_master_nack, o_master_err, o_forward;
  logic o_video_data_valid, o_horizontal_sync, o_vertical_sync;
  logic i_remote_ack, i_remote_nack, i_remote_err;
  logic [7:0] o_reg_rdata, rd_q, n_ack, n_nack, n_err, n_fwd, seen;
  logic [1:0] reply = 2'h0;
  int fail_count = 0, total_checks = 0, cyc = 0;
  sgc_general_config i_sgc_general_config (.i_clock, .i_rst_n, .i_reg_addr, .i_reg_wr,
    .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_crc_check_en, .i_remote_wr_byte,
    .i_target_is_deser, .i_pass_all, .i_remote_ack, .i_remote_nack, .i_remote_err,
    .o_master_ack, .o_master_nack, .o_master_err, .i_pixel_tick, .i_video_data_valid,
    .i_horizontal_sync_input, .i_vertical_sync_input, .o_video_data_valid,
    .o_horizontal_sync, .o_vertical_sync, .i_addr_valid, .i_addr, .i_remote_target_alias,
    .i_alias_used, .o_forward);
  sgc_remote_model i_sgc_remote_model (.i_clock, .i_kick(i_remote_wr_byte), .i_reply(reply),
    .o_ack(i_remote_ack), .o_nack(i_remote_nack), .o_err(i_remote_err));
  always #2 i_clock = ~i_clock;
  always @(negedge i_clock) begin
    cyc++;
    i_pixel_tick = (cyc % 4) == 0;
  end
  // pulse counters and sticky video levels
  always @(posedge i_clock) begin
    n_ack += {7'h00, o_master_ack};
    n_nack += {7'h00, o_master_nack};
    n_err += {7'h00, o_master_err};
    n_fwd += {7'h00, o_forward};
    seen |= {5'h00, o_video_data_valid, o_horizontal_sync, o_vertical_sync};
  end
  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wait_n(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    @(negedge i_clock);
    i_reg_wr = 0;
  endtask
  task rd(input logic [7:0] a);
    @(negedge i_clock);
    i_reg_addr = a;
    i_reg_rd = 1;
    @(negedge i_clock);
    i_reg_rd = 0;
    rd_q = o_reg_rdata;
  endtask
  task byte_w(input logic d, input logic all, input logic [1:0] r);
    {n_ack, n_nack, n_err} = 24'h0;
    @(negedge i_clock);
    {i_target_is_deser, i_pass_all, reply, i_remote_wr_byte} = {d, all, r, 1'b1};
    @(negedge i_clock);
    i_remote_wr_byte = 0;
    wait_n(6);
  endtask
  task adr(input logic [6:0] a);
    n_fwd = 0;
    @(negedge i_clock);
    {i_addr, i_addr_valid} = {a, 1'b1};
    @(negedge i_clock);
    i_addr_valid = 0;
    wait_n(3);
  endtask
  task pins(input int n);
    seen = 0;
    @(negedge i_clock);
    {i_video_data_valid, i_horizontal_sync_input, i_vertical_sync_input} = 3'h7;
    wait_n(n);
    {i_video_data_valid, i_horizontal_sync_input, i_vertical_sync_input} = 3'h0;
    wait_n(30);
  endtask
  initial begin
    #20000;
    fail_count++;
    close_out;
  end
  task t_reset_state;
    rd(8'h03);
    chk("cfg_reset", rd_q, 8'hD2);
    chk("crc_reset", {7'h00, o_crc_check_en}, 8'h01);
    rd(8'h04);
    chk("unmapped", rd_q, 8'h00);
    wr(8'h04, 8'h00);
    rd(8'h03);
    chk("cfg_misaddressed", rd_q, 8'hD2);
    chk("crc_misaddressed", {7'h00, o_crc_check_en}, 8'h01);
  endtask
  task t_remote_passed;
    byte_w(1, 0, 2'h2);
    chk("nack_passed", n_nack, 8'h01);
    chk("no_auto_ack", n_ack, 8'h00);
    byte_w(1, 0, 2'h3);
    chk("err_passed", n_err, 8'h01);
    byte_w(1, 0, 2'h1);
    chk("ack_passed", n_ack, 8'h01);
  endtask
  task t_fwd_off;
    adr(7'h11);
    chk("fwd_off", n_fwd, 8'h00);
  endtask
  task t_filter_on;
    pins(2);
    chk("short_rejected", seen, 8'h00);
    pins(4);
    chk("one_tick_rejected", seen, 8'h00);
    pins(30);
    chk("long_accepted", seen, 8'h07);
  endtask
  task t_cfg_writes;
    wr(8'h03, 8'h00);
    rd(8'h03);
    chk("cfg_zero", rd_q, 8'h42);
    chk("crc_off", {7'h00, o_crc_check_en}, 8'h00);
    wr(8'h03, 8'hFF);
    rd(8'h03);
    chk("cfg_ones", rd_q, 8'hFA);
    chk("crc_on", {7'h00, o_crc_check_en}, 8'h01);
    wr(8'h03, 8'hA8);
    rd(8'h03);
    chk("cfg_mix", rd_q, 8'hEA);
  endtask
  task t_auto_ack;
    byte_w(1, 0, 2'h2);
    chk("auto_ack", n_ack, 8'h01);
    chk("nack_hidden", n_nack, 8'h00);
    byte_w(0, 1, 2'h3);
    chk("auto_ack_all", n_ack, 8'h01);
    chk("err_hidden", n_err, 8'h00);
    byte_w(1, 0, 2'h1);
    chk("ack_once", n_ack, 8'h01);
    byte_w(0, 0, 2'h0);
    chk("not_eligible", n_ack, 8'h00);
  endtask
  task t_fwd_on;
    adr(7'h11);
    chk("fwd_first", n_fwd, 8'h01);
    adr(7'h2A);
    chk("fwd_last", n_fwd, 8'h01);
    adr(7'h33);
    chk("fwd_unused", n_fwd, 8'h00);
  endtask
  task t_filter_off;
    pins(2);
    chk("unfiltered", seen, 8'h07);
  endtask
  task t_mid_reset;
    @(negedge i_clock);
    i_rst_n = 0;
    wait_n(3);
    i_rst_n = 1;
    rd(8'h03);
    chk("cfg_after_reset", rd_q, 8'hD2);
    chk("crc_after_reset", {7'h00, o_crc_check_en}, 8'h01);
    pins(2);
    chk("filter_after_reset", seen, 8'h00);
  endtask
  initial begin
    wait_n(10);
    i_rst_n = 1;
    t_reset_state;
    t_remote_passed;
    t_fwd_off;
    t_filter_on;
    t_cfg_writes;
    t_auto_ack;
    t_fwd_on;
    t_filter_off;
    t_mid_reset;
    close_out;
  end
endmodule // serializer_general_config_tb

// [sim/sgc_remote_model.sv]
`timescale 1ns/1ps
module sgc_remote_model (
  input  wire logic       i_clock,
  input  wire logic       i_kick,
  input  wire logic [1:0] i_reply,
  output logic            o_ack,
  output logic            o_nack,
  output logic            o_err
);
  // remote answers a byte two cycles later
  logic [1:0] d1_q;
  logic [1:0] d2_q;
  always_ff @(posedge i_clock) begin
    d1_q <= i_kick ? i_reply : 2'h0;
    d2_q <= d1_q;
  end
  assign o_ack  = d2_q == 2'h1;
  assign o_nack = d2_q == 2'h2;
  assign o_err  = d2_q == 2'h3;
endmodule // sgc_remote_model

// [src/sgc_general_config.sv]
`timescale 1ns/1ps
module sgc_general_config
  import sgc_pkg::*;
(
  input  wire logic                              i_clock,
  input  wire logic                              i_rst_n,
  input  wire logic [7:0]                        i_reg_addr,
  input  wire logic                              i_reg_wr,
  input  wire logic [7:0]                        i_reg_wdata,
  input  wire logic                              i_reg_rd,
  output logic      [7:0]                        o_reg_rdata,
  output logic                                   o_crc_check_en,
  input  wire logic                              i_remote_wr_byte,
  input  wire logic                              i_target_is_deser,
  input  wire logic                              i_pass_all,
  input  wire logic                              i_remote_ack,
  input  wire logic                              i_remote_nack,
  input  wire logic                              i_remote_err,
  output logic                                   o_master_ack,
  output logic                                   o_master_nack,
  output logic                                   o_master_err,
  input  wire logic                              i_pixel_tick,
  input  wire logic                              i_video_data_valid,
  input  wire logic                              i_horizontal_sync_input,
  input  wire logic                              i_vertical_sync_input,
  output logic                                   o_video_data_valid,
  output logic                                   o_horizontal_sync,
  output logic                                   o_vertical_sync,
  input  wire logic                              i_addr_valid,
  input  wire logic [ADDR_WIDTH-1:0]             i_addr,
  input  wire logic [ALIAS_COUNT*ADDR_WIDTH-1:0] i_remote_target_alias,
  input  wire logic [ALIAS_COUNT-1:0]            i_alias_used,
  output logic                                   o_forward
);

  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] rdata_q;
  logic       cfg_sel;
  logic       cfg_wr;
  logic       auto_ack;
  logic       filt_en;
  logic       pass_en;
  logic       auto_eligible;
  logic       ack_q;
  logic       nack_q;
  logic       err_q;
  logic       fwd_q;
  logic       alias_hit;
  logic [ALIAS_COUNT-1:0] alias_match;
  logic [VIDEO_CHANS-1:0] vid_in;
  logic [VIDEO_CHANS-1:0] vid_out;

  // register access
  assign cfg_sel  = (i_reg_addr == GEN_CFG_OFFSET);
  assign cfg_wr   = i_reg_wr & cfg_sel;
  assign cfg_d    = (i_reg_wdata & GEN_CFG_RW_MASK) | (GEN_CFG_RESET & ~GEN_CFG_RW_MASK);
  assign auto_ack = cfg_q[AUTO_ACK_BIT];
  assign filt_en  = cfg_q[SYNC_FILTER_BIT];
  assign pass_en  = cfg_q[PASS_THRU_BIT];

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= GEN_CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_reg_rd) begin
      rdata_q <= cfg_sel ? cfg_q : 8'h00;
    end
  end

  assign o_reg_rdata    = rdata_q;
  assign o_crc_check_en = cfg_q[CRC_CHECK_EN_BIT];

  // acknowledge path toward the local master
  assign auto_eligible = i_remote_wr_byte & auto_ack & (i_target_is_deser | i_pass_all);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q  <= 1'b0;
      nack_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      ack_q  <= auto_eligible | (~auto_ack & i_remote_ack);
      nack_q <= ~auto_ack & i_remote_nack;
      err_q  <= ~auto_ack & i_remote_err;
    end
  end

  assign o_master_ack  = ack_q;
  assign o_master_nack = nack_q;
  assign o_master_err  = err_q;

  // video control inputs: sync then two-pixel-clock filter
  assign vid_in = {i_vertical_sync_input, i_horizontal_sync_input, i_video_data_valid};

  genvar gc;
  generate
    for (gc = 0; gc < VIDEO_CHANS; gc++) begin : g_vid
      logic [2:0] sync_q;
      logic       clean_q;
      logic       out_q;
      logic [1:0] cnt_q;
      logic       stable;
      assign stable = (sync_q[1] == sync_q[2]);
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync_q  <= 3'h0;
          clean_q <= 1'b0;
        end else begin
          sync_q  <= {sync_q[1:0], vid_in[gc]};
          clean_q <= stable ? sync_q[2] : clean_q;
        end
      end
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          out_q <= 1'b0;
          cnt_q <= 2'h0;
        end else if (!filt_en) begin
          out_q <= clean_q;
          cnt_q <= 2'h0;
        end else if (i_pixel_tick) begin
          if (clean_q == out_q) begin
            cnt_q <= 2'h0;
          end else if (cnt_q == FILTER_TICKS - 2'h1) begin
            out_q <= clean_q;
            cnt_q <= 2'h0;
          end else begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
      end
      assign vid_out[gc] = out_q;
    end
  endgenerate

  assign o_video_data_valid = vid_out[0];
  assign o_horizontal_sync  = vid_out[1];
  assign o_vertical_sync    = vid_out[2];

  // alias match for pass-through
  genvar ga;
  generate
    for (ga = 0; ga < ALIAS_COUNT; ga++) begin : g_alias
      assign alias_match[ga] = i_alias_used[ga] &
        (i_remote_target_alias[ga*ADDR_WIDTH +: ADDR_WIDTH] == i_addr);
    end
  endgenerate

  assign alias_hit = |alias_match;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fwd_q <= 1'b0;
    end else begin
      fwd_q <= i_addr_valid & pass_en & alias_hit;
    end
  end

  assign o_forward = fwd_q;

  a_crc_enable_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cfg_wr |=> o_crc_check_en == $past(i_reg_wdata[CRC_CHECK_EN_BIT]))
    else $error("crc enable did not follow write");

  a_auto_ack_now: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    auto_eligible |=> o_master_ack)
    else $error("remote write not acknowledged at once");

  a_nack_blocked: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (auto_ack && (i_remote_nack || i_remote_err)) |=> !o_master_nack && !o_master_err)
    else $error("remote error passed under auto acknowledge");

  a_filter_on_tick: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (filt_en && $past(filt_en) && $changed(o_vertical_sync)) |-> $past(i_pixel_tick))
    else $error("filtered output changed without pixel tick");

  a_filter_reset_on: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> filt_en)
    else $error("filter not enabled after reset");

  a_pass_forward: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_addr_valid && pass_en && alias_hit) |=> o_forward)
    else $error("alias match not forwarded");

  a_pass_blocked: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!pass_en || !i_addr_valid) |=> !o_forward)
    else $error("forward without pass-through");

  a_reserved_keep: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (cfg_q & ~GEN_CFG_RW_MASK) == (GEN_CFG_RESET & ~GEN_CFG_RW_MASK))
    else $error("reserved bits changed");

endmodule // sgc_general_config
